// ### design/bctl_cpu_end.sv
// processor end: runs cycles and acts on their termination
`timescale 1ns/1ps
`include "bctl_params.svh"
module bctl_cpu_end
  import bctl_pkg::*;
(
  bctl_if.cpu                      BUS,
  input  wire logic                I_SYS_CLK,
  input  wire logic                I_RESET_N,
  input  wire logic                I_REQ_VALID,
  input  wire logic [`BCTL_AW-1:0] I_REQ_ADDR,
  input  wire logic                I_REQ_WRITE,
  input  wire logic                I_REQ_LINE,
  input  wire logic                I_REQ_BURST_INH,
  input  wire bctl_kind_type       I_REQ_KIND,
  input  wire logic [3:0]          I_REQ_NEED,
  input  wire logic                I_REQ_MISALIGN,
  input  wire logic                I_REQ_LOCK,
  input  wire logic                I_REQ_LOCK_LAST,
  input  wire logic                I_EXC_STACKING,
  input  wire logic                I_FETCH_USE,
  input  wire logic                I_FETCH_DISCARD,
  input  wire logic                I_SNOOP_INVAL_PUSH,
  output logic                     O_REQ_READY,
  output logic                     O_DONE,
  output logic                     O_DONE_ERR,
  output bctl_cache_act_type       O_CACHE_ACT,
  output logic                     O_LINE_INVAL,
  output logic                     O_ACCESS_EXC,
  output logic                     O_RD_VALID,
  output logic [`BCTL_DW-1:0]      O_RD_DATA,
  output logic                     O_VEC_VALID,
  output logic [7:0]               O_VECTOR,
  output logic                     O_HALTED
);
  bctl_state_type     state_q, state_d;
  bctl_term_type      term;
  bctl_kind_type      kind_q;
  bctl_cache_act_type cache_act_q;
  logic [`BCTL_AW-1:0] addr_q;
  logic [1:0]         beat_q;
  logic [3:0]         need_q;
  logic               write_q, line_q, binh_q, misalign_q, lock_q, lock_last_q;
  logic               start_q, req_q, oe_q, hold_q, final_q, lost_q;
  logic               ready_q, done_q, done_err_q, line_inval_q, exc_q;
  logic               rd_valid_q, vec_valid_q, halted_q, fetch_err_q;
  logic [`BCTL_DW-1:0] rd_data_q;
  logic [7:0]         vector_q;
  logic               sample, last_beat, retry_ok, berr_eff, imm_err, dbl_fault;
  logic               push_kill, accept, finish, finish_err, fetch_err_set;

  // cache effect of an errored access, by kind
  function automatic bctl_cache_act_type f_cache_act(input bctl_kind_type k);
    unique case (k)
      K_FILL:       f_cache_act = CA_KEEP_INVALID;
      K_FILL_DIRTY: f_cache_act = CA_RESTORE;
      K_PUSH_REPL:  f_cache_act = CA_KEEP_NEW;
      K_PUSH_EXPL:  f_cache_act = CA_INVALIDATE;
      K_WTHRU:      f_cache_act = CA_KEEP_NEW;
      default:      f_cache_act = CA_NONE;
    endcase
  endfunction

  bctl_term_dec u_dec (
    .i_ack  (BUS.cycle_ack_in),
    .i_err  (BUS.error_ack_in),
    .o_term (term)
  );

  // termination decisions; sampling skips the start cycle itself
  always_comb begin
    sample    = (state_q == ST_XFER) && !start_q;
    last_beat = !line_q || (beat_q == `BCTL_LAST_BEAT);
    retry_ok  = (term == TERM_RETRY) && (beat_q == `BCTL_FIRST_BEAT);
    // late line retry is handled exactly like a bus error
    berr_eff  = sample && ((term == TERM_BERR) || ((term == TERM_RETRY) && !retry_ok));
    // first-beat retries never reach this term, so they cannot double fault
    dbl_fault = berr_eff && I_EXC_STACKING && (kind_q != K_IACK);
    imm_err   = write_q
              || (need_q[beat_q] && (kind_q != K_FETCH))
              || (misalign_q && (beat_q <= `BCTL_SECOND_BEAT));
    push_kill = (state_q == ST_ARB) && lost_q && I_SNOOP_INVAL_PUSH
              && ((kind_q == K_PUSH_REPL) || (kind_q == K_PUSH_EXPL));
    accept    = (state_q == ST_IDLE) && I_REQ_VALID;
    finish_err = berr_eff && !dbl_fault;
    finish    = finish_err || push_kill || (sample && (term == TERM_NORMAL) && last_beat);
    fetch_err_set = finish_err && (kind_q == K_FETCH);
  end

  // next state; halt is left only through reset
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_ARB;
        end
      end
      ST_ARB: begin
        if (push_kill) begin
          state_d = ST_IDLE;
        end else if (BUS.ownership_grant) begin
          state_d = ST_XFER;
        end
      end
      ST_XFER: begin
        if (dbl_fault) begin
          state_d = ST_HALT;
        end else if (finish) begin
          state_d = ST_IDLE;
        end else if (sample && retry_ok && !BUS.ownership_grant) begin
          state_d = ST_ARB;
        end
      end
      ST_HALT: state_d = ST_HALT;
    endcase
  end

  // state register
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // access info held unchanged so a retry reissues the same cycle
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      addr_q      <= '0;
      write_q     <= 1'b0;
      line_q      <= 1'b0;
      binh_q      <= 1'b0;
      kind_q      <= K_DATA;
      need_q      <= 4'h0;
      misalign_q  <= 1'b0;
      lock_q      <= 1'b0;
      lock_last_q <= 1'b0;
    end else if (accept) begin
      addr_q      <= I_REQ_ADDR;
      write_q     <= I_REQ_WRITE;
      line_q      <= I_REQ_LINE;
      binh_q      <= I_REQ_BURST_INH;
      kind_q      <= I_REQ_KIND;
      need_q      <= I_REQ_NEED;
      misalign_q  <= I_REQ_MISALIGN;
      lock_q      <= I_REQ_LOCK;
      lock_last_q <= I_REQ_LOCK_LAST;
    end
  end

  // beat count and start strobe; inhibited lines restart per beat
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      beat_q  <= `BCTL_FIRST_BEAT;
      start_q <= 1'b0;
      lost_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (accept) begin
        beat_q <= `BCTL_FIRST_BEAT;
        lost_q <= 1'b0;
      end
      if ((state_q == ST_ARB) && BUS.ownership_grant && !push_kill) begin
        start_q <= 1'b1;
      end
      if (sample && (term == TERM_NORMAL) && !last_beat) begin
        beat_q  <= beat_q + 2'h1;
        start_q <= binh_q;
      end
      if (sample && retry_ok && !dbl_fault) begin
        start_q <= BUS.ownership_grant;
        lost_q  <= !BUS.ownership_grant;
      end
    end
  end

  // bus ownership request and drive enable
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      req_q <= 1'b0;
      oe_q  <= 1'b1;
    end else begin
      req_q <= (state_d == ST_ARB) || (state_d == ST_XFER);
      oe_q  <= (state_d != ST_HALT);
    end
  end

  // locked sequence marks survive every retry of their cycles
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      hold_q  <= 1'b0;
      final_q <= 1'b0;
    end else if (state_d == ST_HALT) begin
      hold_q  <= 1'b0;
      final_q <= 1'b0;
    end else begin
      if (accept && I_REQ_LOCK) begin
        hold_q <= 1'b1;
      end else if (finish && lock_last_q) begin
        hold_q <= 1'b0;
      end
      if (accept) begin
        final_q <= I_REQ_LOCK && I_REQ_LOCK_LAST;
      end else if (finish) begin
        final_q <= 1'b0;
      end
    end
  end

  // completion reporting and cache effects
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ready_q      <= 1'b0;
      done_q       <= 1'b0;
      done_err_q   <= 1'b0;
      cache_act_q  <= CA_NONE;
      line_inval_q <= 1'b0;
      rd_valid_q   <= 1'b0;
      rd_data_q    <= '0;
      vec_valid_q  <= 1'b0;
      vector_q     <= 8'h00;
      halted_q     <= 1'b0;
    end else begin
      ready_q      <= (state_d == ST_IDLE);
      done_q       <= finish;
      done_err_q   <= finish_err;
      cache_act_q  <= finish_err ? f_cache_act(kind_q) : CA_NONE;
      // replaced line dropped before the fill cycle ever starts
      line_inval_q <= accept && ((I_REQ_KIND == K_FILL) || (I_REQ_KIND == K_FILL_DIRTY));
      rd_valid_q   <= sample && (term == TERM_NORMAL) && !write_q;
      rd_data_q    <= BUS.rd_data;
      vec_valid_q  <= sample && (kind_q == K_IACK) && ((term == TERM_NORMAL) || (term == TERM_BERR));
      vector_q     <= (term == TERM_BERR) ? `BCTL_SPUR_VEC : BUS.rd_data[7:0];
      halted_q     <= (state_d == ST_HALT);
    end
  end

  // prefetch errors wait for use; a discard drops them, set wins
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      fetch_err_q <= 1'b0;
      exc_q       <= 1'b0;
    end else begin
      fetch_err_q <= fetch_err_set || (fetch_err_q && !I_FETCH_DISCARD && !I_FETCH_USE);
      exc_q       <= (finish_err && imm_err && (kind_q != K_IACK))
                   || (fetch_err_q && I_FETCH_USE && !I_FETCH_DISCARD);
    end
  end

  assign BUS.start             = start_q;
  assign BUS.addr              = addr_q;
  assign BUS.write             = write_q;
  assign BUS.line              = line_q;
  assign BUS.burst_inh         = binh_q;
  assign BUS.beat              = beat_q;
  assign BUS.atomic_hold       = hold_q;
  assign BUS.atomic_final      = final_q;
  assign BUS.ownership_request = req_q;
  assign BUS.bus_oe            = oe_q;
  assign BUS.proc_status_code  = halted_q ? `BCTL_PST_HALT : `BCTL_PST_RUN;
  assign O_REQ_READY           = ready_q;
  assign O_DONE                = done_q;
  assign O_DONE_ERR            = done_err_q;
  assign O_CACHE_ACT           = cache_act_q;
  assign O_LINE_INVAL          = line_inval_q;
  assign O_ACCESS_EXC          = exc_q;
  assign O_RD_VALID            = rd_valid_q;
  assign O_RD_DATA             = rd_data_q;
  assign O_VEC_VALID           = vec_valid_q;
  assign O_VECTOR              = vector_q;
  assign O_HALTED              = halted_q;
endmodule

// ### design/bctl_params.svh
// constants and overview for the bus cycle termination control block
// Overview of operation
// - responder moves both termination inputs together
// - decode error, retry, normal, wait from pair
// - monitor may raise error when nobody acknowledges
// - bus error ends access, line abandoned
// - prefetch error trapped only when word used
// - unneeded line beat error: line left uncached
// - misaligned span error on beat one/two immediate
// - write or requested read error traps immediately
// - invalidate replaced line before fill, keep invalid
// - dirty replacement error restores line from buffer
// - push error: replacement keeps, explicit push invalidates
// - write-through error leaves line valid, new data
// - retry reissues same address and attributes
// - snoop-killed push after lost bus not reissued
// - atomic hold and final held across retries
// - burst retry after first beat is error
// - inhibited line retry only on first beat
// - grant dropped with retry: release, retry later
// - error while stacking state is double fault
// - double fault halts, status code five, reset only
// - halted device drops request, floats outputs, still drives status code
// - first-beat retries never count as errors, repeat forever
// - interrupt acknowledge error gives spurious vector 24
`ifndef BCTL_PARAMS_SVH
`define BCTL_PARAMS_SVH
`define BCTL_AW          32
`define BCTL_DW          32
`define BCTL_PST_RUN     4'h0
`define BCTL_PST_HALT    4'h5
`define BCTL_SPUR_VEC    8'h18
`define BCTL_FIRST_BEAT  2'h0
`define BCTL_SECOND_BEAT 2'h1
`define BCTL_LAST_BEAT   2'h3
`define BCTL_TIMEOUT_DEF 16
`endif

// ### design/bctl_pkg.sv
// shared types of the bus cycle termination control block
package bctl_pkg;
  typedef enum logic [1:0] {
    TERM_WAIT   = 2'h0,
    TERM_NORMAL = 2'h1,
    TERM_BERR   = 2'h2,
    TERM_RETRY  = 2'h3
  } bctl_term_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARB  = 2'h1,
    ST_XFER = 2'h3,
    ST_HALT = 2'h2
  } bctl_state_type;
  typedef enum logic [2:0] {
    K_FETCH      = 3'h0,
    K_DATA       = 3'h1,
    K_FILL       = 3'h2,
    K_FILL_DIRTY = 3'h3,
    K_PUSH_REPL  = 3'h4,
    K_PUSH_EXPL  = 3'h5,
    K_WTHRU      = 3'h6,
    K_IACK       = 3'h7
  } bctl_kind_type;
  typedef enum logic [2:0] {
    CA_NONE         = 3'h0,
    CA_KEEP_INVALID = 3'h1,
    CA_RESTORE      = 3'h2,
    CA_KEEP_NEW     = 3'h3,
    CA_INVALIDATE   = 3'h4
  } bctl_cache_act_type;
  typedef enum logic [1:0] {
    RESP_NORMAL = 2'h0,
    RESP_ERROR  = 2'h1,
    RESP_RETRY  = 2'h2
  } bctl_resp_type;
endpackage

// ### design/bctl_if.sv
// bus between the processor end and the responder end
`timescale 1ns/1ps
interface bctl_if;
  logic        start;
  logic [31:0] addr;
  logic        write;
  logic        line;
  logic        burst_inh;
  logic [1:0]  beat;
  logic        atomic_hold;
  logic        atomic_final;
  logic        ownership_request;
  logic        bus_oe;
  logic [3:0]  proc_status_code;
  logic        cycle_ack_in;
  logic        error_ack_in;
  logic        ownership_grant;
  logic [31:0] rd_data;
  modport cpu (
    output start, addr, write, line, burst_inh, beat, atomic_hold, atomic_final,
           ownership_request, bus_oe, proc_status_code,
    input  cycle_ack_in, error_ack_in, ownership_grant, rd_data
  );
  modport slave (
    input  start, addr, write, line, burst_inh, beat, atomic_hold, atomic_final,
           ownership_request, bus_oe, proc_status_code,
    output cycle_ack_in, error_ack_in, ownership_grant, rd_data
  );
endinterface

// ### design/bctl_term_dec.sv
// decoder of the termination input pair
`timescale 1ns/1ps
module bctl_term_dec
  import bctl_pkg::*;
(
  input  wire logic    i_ack,
  input  wire logic    i_err,
  output bctl_term_type o_term
);
  // one code per sampled combination
  always_comb begin
    unique case ({i_ack, i_err})
      2'b01:   o_term = TERM_BERR;
      2'b11:   o_term = TERM_RETRY;
      2'b10:   o_term = TERM_NORMAL;
      default: o_term = TERM_WAIT;
    endcase
  end
endmodule

// ### design/bctl_slave_end.sv
// responder end: slave answers, timeout monitor and grant
`timescale 1ns/1ps
`include "bctl_params.svh"
module bctl_slave_end
  import bctl_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `BCTL_TIMEOUT_DEF
) (
  bctl_if.slave                    BUS,
  input  wire logic                I_SYS_CLK,
  input  wire logic                I_RESET_N,
  input  wire logic                I_GRANT,
  input  wire logic                I_RESP_VALID,
  input  wire bctl_resp_type       I_RESP_KIND,
  input  wire logic [`BCTL_DW-1:0] I_RESP_DATA,
  output logic                     O_CYC_OPEN,
  output logic [`BCTL_AW-1:0]      O_CYC_ADDR,
  output logic                     O_CYC_WRITE,
  output logic [1:0]               O_CYC_BEAT,
  output logic                     O_TIMEOUT
);
  logic               open_q, ack_q, err_q, grant_q, tmo_q;
  logic [15:0]        cnt_q;
  logic [`BCTL_AW-1:0] addr_q;
  logic               write_q;
  logic [1:0]         beat_q;
  logic [`BCTL_DW-1:0] data_q;
  logic               answer, expire, more;

  // a burst stays open after a normal beat that is not the last
  always_comb begin
    answer = open_q && I_RESP_VALID && !ack_q && !err_q;
    expire = open_q && !answer && !ack_q && !err_q && (cnt_q == 16'(TIMEOUT_CYCLES - 1));
    more   = BUS.line && !BUS.burst_inh && (BUS.beat != `BCTL_LAST_BEAT)
           && (I_RESP_KIND == RESP_NORMAL);
  end

  // cycle tracking and timeout count
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      open_q <= 1'b0;
      cnt_q  <= 16'h0000;
      tmo_q  <= 1'b0;
    end else begin
      tmo_q <= expire;
      if (BUS.start) begin
        open_q <= 1'b1;
        cnt_q  <= 16'h0000;
      end else if (answer) begin
        open_q <= more;
        cnt_q  <= 16'h0000;
      end else if (expire) begin
        open_q <= 1'b0;
      end else if (open_q && !ack_q && !err_q) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // both inputs rise and fall on the same edge, one cycle wide
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      data_q <= '0;
    end else begin
      ack_q  <= answer && (I_RESP_KIND != RESP_ERROR);
      err_q  <= (answer && (I_RESP_KIND != RESP_NORMAL)) || expire;
      data_q <= answer ? I_RESP_DATA : data_q;
    end
  end

  // arbiter grant and captured cycle view
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      grant_q <= 1'b0;
      addr_q  <= '0;
      write_q <= 1'b0;
      beat_q  <= 2'h0;
    end else begin
      // grant may fall during a retry to force a release
      grant_q <= I_GRANT;
      if (BUS.start) begin
        addr_q  <= BUS.addr;
        write_q <= BUS.write;
      end
      beat_q <= BUS.beat;
    end
  end

  assign BUS.cycle_ack_in    = ack_q;
  assign BUS.error_ack_in    = err_q;
  assign BUS.ownership_grant = grant_q;
  assign BUS.rd_data         = data_q;
  assign O_CYC_OPEN          = open_q;
  assign O_CYC_ADDR          = addr_q;
  assign O_CYC_WRITE         = write_q;
  assign O_CYC_BEAT          = beat_q;
  assign O_TIMEOUT           = tmo_q;
endmodule

// ### sim/bctl_assertions.sv
// concurrent checks on the bus joining the processor end and the responder end
`timescale 1ns/1ps
module bctl_assertions #(
  parameter int TIMEOUT_CYCLES = 16
) (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RESET_N,
  input wire logic        start,
  input wire logic [31:0] addr,
  input wire logic        line,
  input wire logic [1:0]  beat,
  input wire logic        atomic_hold,
  input wire logic        atomic_final,
  input wire logic        ownership_request,
  input wire logic        bus_oe,
  input wire logic [3:0]  proc_status_code,
  input wire logic        cycle_ack_in,
  input wire logic        error_ack_in,
  input wire logic        ownership_grant
);
  // slack covers the opening edge and the error pulse itself
  localparam int TO_LIM = TIMEOUT_CYCLES + 3;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  pair_release_a: assert property (cycle_ack_in && error_ack_in |=> !cycle_ack_in && !error_ack_in)
    else $error("retry pair not released together");
  err_single_a: assert property (error_ack_in |=> !error_ack_in)
    else $error("error pulse longer than one cycle");
  monitor_bound_a: assert property (start |-> ##[1:TO_LIM] (cycle_ack_in || error_ack_in))
    else $error("cycle left without termination");
  normal_end_a: assert property (cycle_ack_in && !error_ack_in && !line |=> !start && !ownership_request)
    else $error("normal termination did not end the cycle");
  retry_same_a: assert property (cycle_ack_in && error_ack_in && ownership_grant && beat == 2'h0
    |=> start && addr == $past(addr)) else $error("retry not reissued with same address");
  retry_late_a: assert property (cycle_ack_in && error_ack_in && beat != 2'h0 |=> !start)
    else $error("late line retry was reissued");
  lost_grant_a: assert property (cycle_ack_in && error_ack_in && !ownership_grant && beat == 2'h0
    |=> !start && ownership_request) else $error("retry without grant not deferred");
  start_granted_a: assert property (start |-> bus_oe && ownership_request && $past(ownership_grant))
    else $error("cycle started without ownership");
  lock_hold_a: assert property (cycle_ack_in && error_ack_in && atomic_hold |=> atomic_hold)
    else $error("atomic hold dropped during retry");
  lock_final_a: assert property (cycle_ack_in && error_ack_in && atomic_final |=> atomic_final)
    else $error("atomic final dropped during retry");
  halt_release_a: assert property (proc_status_code == 4'h5 |-> !bus_oe && !ownership_request)
    else $error("halted end still holds the bus");
  halt_sticky_a: assert property (!bus_oe |=> !bus_oe && proc_status_code == 4'h5)
    else $error("halt left without reset");
endmodule

// ### sim/tb.sv
// self-checking bench joining the processor end and the responder end
`timescale 1ns/1ps
module tb;
  import bctl_pkg::*;
  localparam int TO = 4;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               req_valid = 1'b0;
  logic [31:0]        req_addr = 32'h0;
  logic               req_write = 1'b0;
  logic               req_line = 1'b0;
  logic               req_binh = 1'b0;
  bctl_kind_type      req_kind = K_DATA;
  logic [3:0]         req_need = 4'h0;
  logic               req_mis = 1'b0;
  logic               lock = 1'b0;
  logic               lock_last = 1'b0;
  logic               stacking = 1'b0;
  logic               f_use = 1'b0;
  logic               f_disc = 1'b0;
  logic               snoop = 1'b0;
  logic               grant = 1'b1;
  logic               rv = 1'b0;
  bctl_resp_type      rk = RESP_NORMAL;
  logic               rdy, done, done_err, l_inv, exc, rd_v, vec_v, halted, c_open, t_out, d_err, c_wr;
  bctl_cache_act_type act, d_act;
  logic [31:0]        rd_data, c_addr;
  logic [7:0]         vector, vec;
  logic [1:0]         c_beat;
  int                 n_st, n_rd, n_exc, n_inv, n_to, n_dn, err_total, n_compared;
  bctl_if bctl_if_i ();
  bctl_cpu_end bctl_cpu_end_i (.BUS(bctl_if_i), .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_REQ_VALID(req_valid),
    .I_REQ_ADDR(req_addr), .I_REQ_WRITE(req_write), .I_REQ_LINE(req_line), .I_REQ_BURST_INH(req_binh),
    .I_REQ_KIND(req_kind), .I_REQ_NEED(req_need), .I_REQ_MISALIGN(req_mis), .I_REQ_LOCK(lock),
    .I_REQ_LOCK_LAST(lock_last), .I_EXC_STACKING(stacking), .I_FETCH_USE(f_use), .I_FETCH_DISCARD(f_disc),
    .I_SNOOP_INVAL_PUSH(snoop), .O_REQ_READY(rdy), .O_DONE(done), .O_DONE_ERR(done_err), .O_CACHE_ACT(act),
    .O_LINE_INVAL(l_inv), .O_ACCESS_EXC(exc), .O_RD_VALID(rd_v), .O_RD_DATA(rd_data), .O_VEC_VALID(vec_v),
    .O_VECTOR(vector), .O_HALTED(halted));
  // small timeout keeps the monitor scenario short
  bctl_slave_end #(.TIMEOUT_CYCLES(TO)) bctl_slave_end_i (.BUS(bctl_if_i), .I_SYS_CLK(clk), .I_RESET_N(rst_n),
    .I_GRANT(grant), .I_RESP_VALID(rv), .I_RESP_KIND(rk), .I_RESP_DATA(32'h5A5A_1234), .O_CYC_OPEN(c_open),
    .O_CYC_ADDR(c_addr), .O_CYC_WRITE(c_wr), .O_CYC_BEAT(c_beat), .O_TIMEOUT(t_out));
  bctl_assertions #(.TIMEOUT_CYCLES(TO)) bctl_assertions_i (.I_SYS_CLK(clk), .I_RESET_N(rst_n),
    .start(bctl_if_i.start), .addr(bctl_if_i.addr), .line(bctl_if_i.line), .beat(bctl_if_i.beat),
    .atomic_hold(bctl_if_i.atomic_hold), .atomic_final(bctl_if_i.atomic_final),
    .ownership_request(bctl_if_i.ownership_request), .bus_oe(bctl_if_i.bus_oe),
    .proc_status_code(bctl_if_i.proc_status_code), .cycle_ack_in(bctl_if_i.cycle_ack_in),
    .error_ack_in(bctl_if_i.error_ack_in), .ownership_grant(bctl_if_i.ownership_grant));
  always #5 clk = ~clk;
  // pulse counters, sampled mid-cycle
  always @(negedge clk) begin
    if (bctl_if_i.start === 1'b1) n_st++;
    if (rd_v === 1'b1) n_rd++;
    if (exc === 1'b1) n_exc++;
    if (l_inv === 1'b1) n_inv++;
    if (t_out === 1'b1) n_to++;
    if (vec_v === 1'b1) vec = vector;
    if (done === 1'b1) begin
      n_dn++;
      d_err = done_err;
      d_act = act;
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
  endtask
  // one answer once the cycle is open; gd drops the grant with it
  task automatic resp(input logic [1:0] k, input logic gd);
    int t;
    t = 0;
    while (!(c_open === 1'b1 && bctl_if_i.cycle_ack_in === 1'b0 && bctl_if_i.error_ack_in === 1'b0) && t < 50) begin
      @(negedge clk);
      t++;
    end
    if (t >= 50) hang();
    @(negedge clk);
    rv = 1'b1;
    rk = bctl_resp_type'(k);
    grant = !gd;
    @(negedge clk);
    rv = 1'b0;
    if (gd) begin
      repeat (4) @(negedge clk);
      chk(n_st, 1);
      grant = 1'b1;
    end
  endtask
  // one request with n answers packed two bits each, first answer lowest
  task automatic cyc(input logic [31:0] a, input logic w, ln, bi, input bctl_kind_type kd, input logic [3:0] nd,
                     input logic ms, input int n, input logic [7:0] ks, input logic gd);
    int t;
    t = 0;
    while (rdy !== 1'b1 && t < 50) begin
      @(negedge clk);
      t++;
    end
    if (t >= 50) hang();
    {n_st, n_rd, n_exc, n_inv, n_to, n_dn} = '0;
    {req_addr, req_write, req_line, req_binh, req_need, req_mis} = {a, w, ln, bi, nd, ms};
    req_kind = kd;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (int i = 0; i < n; i++) resp(ks[2*i+:2], gd && i == 0);
    t = 0;
    while (n_dn == 0 && halted !== 1'b1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    if (t >= 100) hang();
    @(negedge clk);
  endtask
  task automatic s_basic();
    cyc(32'h1000_0010, 1'b0, 1'b0, 1'b0, K_DATA, 4'h1, 1'b0, 1, 8'h00, 1'b0);
    chk(d_err, 0);
    chk(rd_data, 32'h5A5A_1234);
    cyc(32'h1000_0020, 1'b1, 1'b0, 1'b0, K_DATA, 4'h0, 1'b0, 1, 8'h01, 1'b0);
    chk(d_err, 1);
    chk(n_exc, 1);
    chk(halted, 0);
    cyc(32'h1000_0030, 1'b0, 1'b0, 1'b0, K_DATA, 4'h1, 1'b0, 0, 8'h00, 1'b0);
    chk(n_to, 1);
    chk(d_err, 1);
  endtask
  task automatic s_fetch();
    cyc(32'h2000_0000, 1'b0, 1'b0, 1'b0, K_FETCH, 4'h0, 1'b0, 1, 8'h01, 1'b0);
    chk(n_exc, 0);
    f_use = 1'b1;
    @(negedge clk);
    f_use = 1'b0;
    repeat (2) @(negedge clk);
    chk(n_exc, 1);
    cyc(32'h2000_0004, 1'b0, 1'b0, 1'b0, K_FETCH, 4'h0, 1'b0, 1, 8'h01, 1'b0);
    f_disc = 1'b1;
    @(negedge clk);
    f_disc = 1'b0;
    f_use = 1'b1;
    @(negedge clk);
    f_use = 1'b0;
    repeat (2) @(negedge clk);
    chk(n_exc, 0);
  endtask
  task automatic s_line();
    cyc(32'h3000_0000, 1'b0, 1'b1, 1'b0, K_FILL, 4'h1, 1'b0, 2, 8'h04, 1'b0);
    chk(d_err, 1);
    chk(n_rd, 1);
    chk(n_exc, 0);
    chk(n_inv, 1);
    chk(c_beat, 2'h1);
    chk(d_act, CA_KEEP_INVALID);
    cyc(32'h3000_0010, 1'b0, 1'b1, 1'b0, K_FILL_DIRTY, 4'h0, 1'b0, 1, 8'h01, 1'b0);
    chk(d_act, CA_RESTORE);
    cyc(32'h3000_0020, 1'b0, 1'b1, 1'b0, K_DATA, 4'h0, 1'b1, 2, 8'h04, 1'b0);
    chk(n_exc, 1);
    cyc(32'h3000_0030, 1'b0, 1'b1, 1'b0, K_FILL, 4'h0, 1'b0, 2, 8'h08, 1'b0);
    chk(d_err, 1);
    cyc(32'h3000_0040, 1'b0, 1'b1, 1'b1, K_FILL, 4'h0, 1'b0, 2, 8'h08, 1'b0);
    chk({d_err, n_st[3:0]}, 5'h12);
  endtask
  task automatic s_push();
    bctl_kind_type k[3] = '{K_PUSH_REPL, K_PUSH_EXPL, K_WTHRU};
    bctl_cache_act_type e[3] = '{CA_KEEP_NEW, CA_INVALIDATE, CA_KEEP_NEW};
    for (int i = 0; i < 3; i++) begin
      cyc(32'h4000_0000, 1'b1, 1'b0, 1'b0, k[i], 4'h0, 1'b0, 1, 8'h01, 1'b0);
      chk(d_act, e[i]);
      chk(c_wr, 1);
    end
  endtask
  task automatic s_retry();
    // retries under stacking must not be taken for a fault
    stacking = 1'b1;
    cyc(32'h5000_0008, 1'b0, 1'b0, 1'b0, K_DATA, 4'h1, 1'b0, 4, 8'h2A, 1'b0);
    stacking = 1'b0;
    chk(n_st, 4);
    chk(c_addr, 32'h5000_0008);
    chk({d_err, halted}, 2'h0);
    cyc(32'h5000_000C, 1'b0, 1'b0, 1'b0, K_DATA, 4'h1, 1'b0, 2, 8'h02, 1'b1);
    chk({d_err, n_st[3:0]}, 5'h02);
    snoop = 1'b1;
    cyc(32'h5000_0010, 1'b1, 1'b0, 1'b0, K_PUSH_REPL, 4'h0, 1'b0, 1, 8'h02, 1'b1);
    snoop = 1'b0;
    chk({d_err, n_dn[3:0], n_st[3:0]}, 9'h011);
    lock = 1'b1;
    cyc(32'h5000_0020, 1'b0, 1'b0, 1'b0, K_DATA, 4'h1, 1'b0, 2, 8'h02, 1'b0);
    chk(bctl_if_i.atomic_hold, 1);
    lock_last = 1'b1;
    cyc(32'h5000_0020, 1'b1, 1'b0, 1'b0, K_DATA, 4'h0, 1'b0, 2, 8'h02, 1'b0);
    chk({d_err, n_st[3:0]}, 5'h02);
    {lock, lock_last} = 2'h0;
  endtask
  task automatic s_halt();
    cyc(32'hFFFF_FFFF, 1'b0, 1'b0, 1'b0, K_IACK, 4'h0, 1'b0, 1, 8'h01, 1'b0);
    chk({vec, n_exc[3:0]}, 12'h180);
    stacking = 1'b1;
    cyc(32'h6000_0000, 1'b0, 1'b0, 1'b0, K_DATA, 4'h1, 1'b0, 1, 8'h01, 1'b0);
    stacking = 1'b0;
    chk({halted, n_dn[3:0]}, 5'h10);
    chk(bctl_if_i.proc_status_code, 4'h5);
    chk({bctl_if_i.bus_oe, bctl_if_i.ownership_request}, 2'h0);
    req_valid = 1'b1;
    repeat (6) @(negedge clk);
    req_valid = 1'b0;
    chk({halted, n_st[3:0]}, 5'h11);
    do_reset();
    @(negedge clk);
    chk({halted, bctl_if_i.proc_status_code}, 5'h00);
  endtask
  initial begin
    {err_total, n_compared} = '0;
    do_reset();
    s_basic();
    s_fetch();
    s_line();
    s_push();
    s_retry();
    s_halt();
    finish_test();
  end
endmodule
